//--- common/ldim_map.svh
`ifndef LDIM_MAP_SVH
`define LDIM_MAP_SVH
// pclk rate and serial clock half period of the controller
`define LDIM_PCLK_MHZ 40
`define LDIM_SCL_HALF_NS 100
// blink step rate: 152 periods per second times 256 duty steps
`define LDIM_BLINK_HZ 152
`define LDIM_DUTY_STEPS 256
// upper six address bits; the select pin supplies bit 0
`define LDIM_ADDR_HI 6'h30
// register pointer codes
`define LDIM_PTR_INPUT 3'h0
`define LDIM_PTR_BLINK_PRESCALER_0 3'h1
`define LDIM_PTR_DUTY_LEVEL_0 3'h2
`define LDIM_PTR_BLINK_PRESCALER_1 3'h3
`define LDIM_PTR_DUTY_LEVEL_1 3'h4
`define LDIM_PTR_SEL 3'h5
// control byte auto-increment bit
`define LDIM_CTRL_STEP_BIT 4
// reset values
`define LDIM_RST_CTRL 8'h00
`define LDIM_RST_PSC 8'h00
`define LDIM_RST_PWM 8'h80
`define LDIM_RST_SEL 8'hf0
// controller register offsets and fields
`define LDIM_OFS_CMD 12'h000
`define LDIM_OFS_STATUS 12'h004
`define LDIM_CMD_START_BIT 8
`define LDIM_CMD_STOP_BIT 9
`define LDIM_CMD_READ_BIT 10
`define LDIM_CMD_NACK_BIT 11
`endif

//--- common/ldim_pkg.sv
package ldim_pkg;
    typedef logic [7:0] ldim_byte_t;
    typedef logic [2:0] ldim_ptr_t;
    typedef enum logic [2:0] {
        S_IDLE, S_RX, S_ACK, S_TX, S_TXACK, S_IGNORE
    } ldim_dev_st_e;
    typedef enum logic [3:0] {
        H_IDLE, H_RS_LO, H_RS_HI, H_START, H_BIT_LO, H_BIT_HI,
        H_STOP_LO, H_STOP_HI, H_STOP_END
    } ldim_host_st_e;
endpackage

//--- common/ldim_link_if.sv
`timescale 1ns/1ps
interface ldim_link_if;
    // open-drain drivers, enable low while pulling the line
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    // resolved lines, pulled up when nobody drives
    logic scl;
    logic sda;
    assign scl = host_scl_oe_n | host_scl_o;
    assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
    modport host (output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n,
        input scl, sda);
    modport dev (output dev_sda_o, dev_sda_oe_n, input scl, sda);
endinterface

//--- src/ldim_slave.sv
`timescale 1ns/1ps
`include "ldim_map.svh"
module ldim_slave (
    // clock, reset and freeze
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // external reset and address strap
    input wire logic ext_reset_n,
    input wire logic addr_select_pin,
    // serial link
    ldim_link_if.dev link,
    // output pins, bit 0 is output_zero, bit 1 output_one
    input wire logic [1:0] out_pin_i,
    output logic [1:0] out_pin_o,
    output logic [1:0] out_pin_oe_n,
    // blink waves, high while the wave is in its on part
    output logic [1:0] blink_wave,
    // stored control byte
    output ldim_pkg::ldim_byte_t ctrl_byte
);
    import ldim_pkg::*;

    localparam int STEP_HZ = `LDIM_BLINK_HZ * `LDIM_DUTY_STEPS;
    localparam int STEP_CYC = `LDIM_PCLK_MHZ * 1000000 / STEP_HZ;

    ////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [5:0] meta_q;
    logic [5:0] stab_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_s;
    logic sda_s;
    logic soft_clr;

    // every pin passes two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 6'h3f;
            stab_q <= 6'h3f;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else if (ce) begin
            meta_q <= {out_pin_i, addr_select_pin, ext_reset_n, link.sda, link.scl};
            stab_q <= meta_q;
            scl_prev_q <= stab_q[0];
            sda_prev_q <= stab_q[1];
        end
    end

    assign scl_s = stab_q[0];
    assign sda_s = stab_q[1];
    assign soft_clr = !stab_q[2];

    ////////////////////////////////////////////////////////////////////
    // bus event detection

    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;

    // idle is both high; edges of data under high clock are conditions
    assign start_ev = scl_s & scl_prev_q & sda_prev_q & !sda_s;
    assign stop_ev = scl_s & scl_prev_q & !sda_prev_q & sda_s;
    assign scl_rise = scl_s & !scl_prev_q;
    assign scl_fall = !scl_s & scl_prev_q;

    ////////////////////////////////////////////////////////////////////
    // registers and helpers

    ldim_dev_st_e st_q;
    logic [3:0] bit_cnt_q;
    ldim_byte_t shift_q;
    logic [1:0] byte_no_q;
    logic rd_q;
    logic ack_q;
    logic sda_oe_n_q;
    ldim_byte_t ctrl_q;
    ldim_byte_t psc_q [2];
    ldim_byte_t pwm_q [2];
    ldim_byte_t sel_q;

    // register read mux, used for every transmitted byte
    function automatic ldim_byte_t read_reg(input ldim_ptr_t p);
        ldim_byte_t r;
        r = 8'h00;
        if (p == `LDIM_PTR_INPUT) begin
            r = {6'h00, stab_q[5:4]};
        end else if (p == `LDIM_PTR_BLINK_PRESCALER_0) begin
            r = psc_q[0];
        end else if (p == `LDIM_PTR_DUTY_LEVEL_0) begin
            r = pwm_q[0];
        end else if (p == `LDIM_PTR_BLINK_PRESCALER_1) begin
            r = psc_q[1];
        end else if (p == `LDIM_PTR_DUTY_LEVEL_1) begin
            r = pwm_q[1];
        end else if (p == `LDIM_PTR_SEL) begin
            r = sel_q;
        end
        return r;
    endfunction

    // pointer step with wrap after the selector
    function automatic ldim_ptr_t next_ptr(input ldim_ptr_t p);
        return (p >= `LDIM_PTR_SEL) ? `LDIM_PTR_INPUT : ldim_ptr_t'(p + 3'h1);
    endfunction

    logic byte_done;
    logic addr_hit;
    logic wr_ctrl;
    logic wr_data;
    logic load_tx;
    ldim_byte_t tx_byte;

    assign byte_done = (st_q == S_RX) & scl_fall & (bit_cnt_q == 4'h8);
    assign addr_hit = (shift_q[7:1] == {`LDIM_ADDR_HI, stab_q[3]});
    assign wr_ctrl = byte_done & (byte_no_q == 2'h1);
    assign wr_data = byte_done & (byte_no_q == 2'h2);
    // a read byte is fetched when the link enters or re-enters transmit
    assign load_tx = scl_fall & (((st_q == S_ACK) & rd_q) | ((st_q == S_TXACK) & ack_q));
    assign tx_byte = read_reg(ctrl_q[2:0]);

    ////////////////////////////////////////////////////////////////////
    // serial state machine

    // start and stop override every state so a stuck transfer recovers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            byte_no_q <= 2'h0;
            rd_q <= 1'b0;
            ack_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
        end else if (ce) begin
            if (soft_clr) begin
                st_q <= S_IDLE;
                sda_oe_n_q <= 1'b1;
            end else if (start_ev) begin
                st_q <= S_RX;
                bit_cnt_q <= 4'h0;
                byte_no_q <= 2'h0;
                sda_oe_n_q <= 1'b1;
            end else if (stop_ev) begin
                st_q <= S_IDLE;
                sda_oe_n_q <= 1'b1;
            end else begin
                case (st_q)
                    S_RX: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (byte_done) begin
                            if (byte_no_q == 2'h0 && !addr_hit) begin
                                st_q <= S_IGNORE;
                            end else begin
                                st_q <= S_ACK;
                                sda_oe_n_q <= 1'b0;
                                if (byte_no_q == 2'h0) begin
                                    rd_q <= shift_q[0];
                                end
                                if (byte_no_q != 2'h2) begin
                                    byte_no_q <= byte_no_q + 2'h1;
                                end
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            if (rd_q) begin
                                st_q <= S_TX;
                                sda_oe_n_q <= tx_byte[7];
                                shift_q <= {tx_byte[6:0], 1'b1};
                            end else begin
                                st_q <= S_RX;
                                sda_oe_n_q <= 1'b1;
                            end
                        end
                    end
                    S_TX: begin
                        if (scl_rise) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_q == 4'h8) begin
                                st_q <= S_TXACK;
                                sda_oe_n_q <= 1'b1;
                            end else begin
                                sda_oe_n_q <= shift_q[7];
                                shift_q <= {shift_q[6:0], 1'b1};
                            end
                        end
                    end
                    S_TXACK: begin
                        if (scl_rise) begin
                            ack_q <= !sda_s;
                        end else if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            if (ack_q) begin
                                st_q <= S_TX;
                                sda_oe_n_q <= tx_byte[7];
                                shift_q <= {tx_byte[6:0], 1'b1};
                            end else begin
                                st_q <= S_IGNORE;
                            end
                        end
                    end
                    default: begin
                        sda_oe_n_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe_n = sda_oe_n_q;

    ////////////////////////////////////////////////////////////////////
    // register file

    // control byte, then data walks through the pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `LDIM_RST_CTRL;
            psc_q[0] <= `LDIM_RST_PSC;
            psc_q[1] <= `LDIM_RST_PSC;
            pwm_q[0] <= `LDIM_RST_PWM;
            pwm_q[1] <= `LDIM_RST_PWM;
            sel_q <= `LDIM_RST_SEL;
        end else if (ce) begin
            if (soft_clr) begin
                ctrl_q <= `LDIM_RST_CTRL;
                psc_q[0] <= `LDIM_RST_PSC;
                psc_q[1] <= `LDIM_RST_PSC;
                pwm_q[0] <= `LDIM_RST_PWM;
                pwm_q[1] <= `LDIM_RST_PWM;
                sel_q <= `LDIM_RST_SEL;
            end else if (wr_ctrl) begin
                ctrl_q <= shift_q;
            end else if (wr_data || load_tx) begin
                if (wr_data) begin
                    // writes to the input register are acked and dropped
                    if (ctrl_q[2:0] == `LDIM_PTR_BLINK_PRESCALER_0) psc_q[0] <= shift_q;
                    if (ctrl_q[2:0] == `LDIM_PTR_DUTY_LEVEL_0) pwm_q[0] <= shift_q;
                    if (ctrl_q[2:0] == `LDIM_PTR_BLINK_PRESCALER_1) psc_q[1] <= shift_q;
                    if (ctrl_q[2:0] == `LDIM_PTR_DUTY_LEVEL_1) pwm_q[1] <= shift_q;
                    if (ctrl_q[2:0] == `LDIM_PTR_SEL) sel_q <= shift_q;
                end
                if (ctrl_q[`LDIM_CTRL_STEP_BIT]) begin
                    ctrl_q[2:0] <= next_ptr(ctrl_q[2:0]);
                end
            end
        end
    end

    assign ctrl_byte = ctrl_q;

    ////////////////////////////////////////////////////////////////////
    // blink generators

    logic [15:0] step_cnt_q;
    logic step_tick;

    // common step of 152*256 per second feeds both prescalers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt_q <= 16'h0000;
        end else if (ce) begin
            if (soft_clr || step_tick) begin
                step_cnt_q <= 16'h0000;
            end else begin
                step_cnt_q <= step_cnt_q + 16'h0001;
            end
        end
    end

    assign step_tick = (step_cnt_q == 16'(STEP_CYC - 1));

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_blink
            ldim_byte_t sub_q;
            ldim_byte_t phase_q;
            logic [1:0] code;
            logic drive_on;

            // phase advances once per prescaler+1 steps
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sub_q <= 8'h00;
                    phase_q <= 8'h00;
                end else if (ce) begin
                    if (soft_clr) begin
                        sub_q <= 8'h00;
                        phase_q <= 8'h00;
                    end else if (step_tick) begin
                        if (sub_q >= psc_q[g]) begin
                            sub_q <= 8'h00;
                            phase_q <= phase_q + 8'h01;
                        end else begin
                            sub_q <= sub_q + 8'h01;
                        end
                    end
                end
            end

            assign blink_wave[g] = (phase_q < pwm_q[g]);

            // selector decode; on pulls the pin low
            assign code = sel_q[2 * g +: 2];
            assign drive_on = (code == 2'b01) || (code == 2'b10 && blink_wave[0])
                || (code == 2'b11 && blink_wave[1]);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_pin_oe_n[g] <= 1'b1;
                end else if (ce) begin
                    out_pin_oe_n[g] <= !drive_on;
                end
            end

            assign out_pin_o[g] = 1'b0;
        end
    endgenerate

endmodule

//--- src/ldim_master.sv
`timescale 1ns/1ps
`include "ldim_map.svh"
module ldim_master (
    // clock, reset and freeze
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial link
    ldim_link_if.host link
);
    import ldim_pkg::*;

    localparam int HALF_CYC = `LDIM_SCL_HALF_NS * `LDIM_PCLK_MHZ / 1000;

    ////////////////////////////////////////////////////////////////////
    // apb access

    logic cmd_wr;
    logic addr_ok;
    logic busy;
    logic [7:0] rx_data;
    logic ack_missing;

    assign addr_ok = (paddr == `LDIM_OFS_CMD) || (paddr == `LDIM_OFS_STATUS);
    assign pready = psel & penable;
    assign pslverr = psel & penable & !addr_ok;
    // a command written while busy is dropped; software polls busy
    assign cmd_wr = psel & penable & pwrite & (paddr == `LDIM_OFS_CMD) & !busy;

    // read data latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (ce && psel && !penable) begin
            if (paddr == `LDIM_OFS_STATUS) begin
                prdata <= {16'h0000, rx_data, 6'h00, ack_missing, busy};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // serial engine

    ldim_host_st_e st_q;
    logic [7:0] tim_q;
    logic [8:0] tx_q;
    logic [8:0] rx_q;
    logic [3:0] bit_q;
    logic stop_q;
    logic scl_q;
    logic sda_q;
    logic [1:0] sda_sync_q;
    logic tick;

    assign busy = (st_q != H_IDLE);
    assign tick = (tim_q == 8'(HALF_CYC - 1));
    assign rx_data = rx_q[8:1];
    assign ack_missing = rx_q[0];

    // data line back from the bus, two flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_sync_q <= 2'b11;
        end else if (ce) begin
            sda_sync_q <= {sda_sync_q[0], link.sda};
        end
    end

    // half-period timer runs only while a command is active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tim_q <= 8'h00;
        end else if (ce) begin
            tim_q <= (!busy || tick) ? 8'h00 : tim_q + 8'h01;
        end
    end

    // each state other than H_IDLE lasts one half period of the serial clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= H_IDLE;
            tx_q <= 9'h1ff;
            rx_q <= 9'h000;
            bit_q <= 4'h0;
            stop_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce) begin
            case (st_q)
                H_IDLE: begin
                    if (cmd_wr) begin
                        stop_q <= pwdata[`LDIM_CMD_STOP_BIT];
                        bit_q <= 4'h0;
                        tx_q <= pwdata[`LDIM_CMD_READ_BIT]
                            ? {8'hff, pwdata[`LDIM_CMD_NACK_BIT]} : {pwdata[7:0], 1'b1};
                        if (!pwdata[`LDIM_CMD_START_BIT]) begin
                            st_q <= H_BIT_LO;
                        end else if (scl_q) begin
                            st_q <= H_START;
                            sda_q <= 1'b0;
                        end else begin
                            st_q <= H_RS_LO;
                            sda_q <= 1'b1;
                        end
                    end
                end
                H_RS_LO: if (tick) begin
                    st_q <= H_RS_HI;
                    scl_q <= 1'b1;
                end
                H_RS_HI: if (tick) begin
                    st_q <= H_START;
                    sda_q <= 1'b0;
                end
                H_START: if (tick) begin
                    st_q <= H_BIT_LO;
                    scl_q <= 1'b0;
                end
                H_BIT_LO: if (tick) begin
                    st_q <= H_BIT_HI;
                    scl_q <= 1'b1;
                end
                H_BIT_HI: if (tick) begin
                    rx_q <= {rx_q[7:0], sda_sync_q[1]};
                    bit_q <= bit_q + 4'h1;
                    scl_q <= 1'b0;
                    st_q <= (bit_q == 4'h8) ? (stop_q ? H_STOP_LO : H_IDLE) : H_BIT_LO;
                end
                H_STOP_LO: if (tick) begin
                    st_q <= H_STOP_HI;
                    scl_q <= 1'b1;
                end
                H_STOP_HI: if (tick) begin
                    st_q <= H_STOP_END;
                    sda_q <= 1'b1;
                end
                H_STOP_END: if (tick) begin
                    st_q <= H_IDLE;
                end
                default: begin
                    st_q <= H_IDLE;
                end
            endcase
            // data changes on the same edge that drives the clock low, or while the clock is already low
            if (tick && st_q == H_BIT_HI && bit_q != 4'h8) begin
                sda_q <= tx_q[8];
                tx_q <= {tx_q[7:0], 1'b1};
            end else if (tick && st_q == H_BIT_HI && stop_q) begin
                sda_q <= 1'b0;
            end else if (tick && st_q == H_START) begin
                sda_q <= tx_q[8];
                tx_q <= {tx_q[7:0], 1'b1};
            // first bit goes out now, so the ack bit sits one place up in the shifter
            end else if (st_q == H_IDLE && cmd_wr && !pwdata[`LDIM_CMD_START_BIT]) begin
                sda_q <= pwdata[`LDIM_CMD_READ_BIT] ? 1'b1 : pwdata[7];
                tx_q <= pwdata[`LDIM_CMD_READ_BIT]
                    ? {7'h7f, pwdata[`LDIM_CMD_NACK_BIT], 1'b1} : {pwdata[6:0], 2'b11};
            end
        end
    end

    assign link.host_scl_o = 1'b0;
    assign link.host_scl_oe_n = scl_q;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe_n = sda_q;

endmodule

//--- sim/ldim_link_properties.sv
`timescale 1ns/1ps
module ldim_link_properties (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link drivers and resolved lines
    input wire logic host_scl_o,
    input wire logic host_sda_o,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // lines are only ever pulled low, the pull-up gives the high
    drain_only_a: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
        else $error("high drive");
    // host pulling sda under a high clock finds the device off the line, which
    // covers the stop after a read nack; both may pull while scl is still low
    no_clash_a: assert property (scl && !host_sda_oe_n |-> dev_sda_oe_n)
        else $error("both pull sda");
    dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("dev moved, scl high");
    scl_low_a: assert property ($fell(scl) |-> !scl [*4])
        else $error("short low phase");
    bit_steady_a: assert property ($rose(scl) |=> $stable(sda) [*2])
        else $error("sda moved, scl high");
    start_hold_a: assert property ($fell(sda) && scl |=> scl [*2])
        else $error("start not held");
    stop_idle_a: assert property ($rose(sda) && scl |=> (sda && scl) [*3])
        else $error("no idle");
    // ack pull spans the whole high phase of the ninth clock
    ack_hold_a: assert property ($fell(dev_sda_oe_n) |=> !dev_sda_oe_n [*6])
        else $error("short pull");
    cover property ($fell(sda) && scl);
    cover property ($rose(scl) && !dev_sda_oe_n);
    cover property ($rose(scl) && host_sda_oe_n && dev_sda_oe_n);
endmodule

//--- sim/test_i2c_led_dimmer_slave_port.sv
`timescale 1ns/1ps
module test_i2c_led_dimmer_slave_port;
    import ldim_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, ext_reset_n = 1'b1, addr_select_pin = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] out_pin_i = 2'h0, out_pin_oe_n, blink_wave;
    ldim_byte_t ctrl_byte;
    ldim_byte_t exp_q [6];
    int n_mismatch = 0, n_checks = 0, seed = 62517;
    ldim_link_if link ();
    ldim_master u_ldim_master (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link.host));
    ldim_slave u_ldim_slave (.pclk(pclk), .presetn(presetn), .ce(1'b1), .ext_reset_n(ext_reset_n),
        .addr_select_pin(addr_select_pin), .link(link.dev), .out_pin_i(out_pin_i), .out_pin_o(),
        .out_pin_oe_n(out_pin_oe_n), .blink_wave(blink_wave), .ctrl_byte(ctrl_byte));
    ldim_link_properties u_props (.pclk(pclk), .presetn(presetn), .host_scl_o(link.host_scl_o),
        .host_sda_o(link.host_sda_o), .host_sda_oe_n(link.host_sda_oe_n),
        .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n), .scl(link.scl),
        .sda(link.sda));
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            n_mismatch++;
            results();
        end
        rd = prdata;
        chk(pslverr, a > 12'h004);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // f is {nack, read, stop, start}; polls busy so the next command is never dropped
    task automatic xfer(input logic [3:0] f, input logic [7:0] b);
        int k;
        apb(1'b1, 12'h000, {20'h0, f, b});
        for (k = 0; k < 100; k++) begin
            apb(1'b0, 12'h004, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        if (k == 100) begin
            n_mismatch++;
            results();
        end
    endtask
    // wave 0 sits high (duty 0x80, early phase), wave 1 low (duty 0)
    function automatic logic [1:0] pin_exp(input logic [7:0] sel);
        for (int i = 0; i < 2; i++) begin
            pin_exp[i] = (sel[2*i +: 2] == 2'b01) ? 1'b0 : (sel[2*i +: 2] == 2'b10) ? 1'b0 : 1'b1;
        end
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        out_pin_i <= 2'($random(seed));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        exp_q = '{{6'h0, out_pin_i}, 8'($random(seed)), 8'h80, 8'($random(seed)), 8'h00, 8'h0e};
        xfer(4'h1, 8'hc0);
        chk(rd[1], 1'b0);
        xfer(4'h0, 8'h11);
        for (int i = 1; i < 6; i++) begin
            xfer({2'b00, i == 5, 1'b0}, exp_q[i]);
            chk(rd[1], 1'b0);
        end
        chk(ctrl_byte, 8'h10);
        chk(out_pin_oe_n, pin_exp(8'h0e));
        chk(blink_wave, 2'b01);
        xfer(4'h1, 8'hc1);
        for (int i = 0; i < 6; i++) begin
            xfer({i == 5, 1'b1, i == 5, 1'b0}, 8'hff);
            chk(rd[15:8], exp_q[i]);
            chk(rd[1], i == 5);
        end
        for (int c = 0; c < 4; c++) begin
            xfer(4'h1, 8'hc0);
            xfer(4'h0, 8'h05);
            xfer(4'h0, {4'h0, 2'(c), 2'(3 - c)});
            // repeated start; the unstepped pointer reads the selector back
            xfer(4'h1, 8'hc1);
            xfer(4'he, 8'hff);
            chk(rd[15:8], {4'h0, 2'(c), 2'(3 - c)});
            chk(out_pin_oe_n, pin_exp({4'h0, 2'(c), 2'(3 - c)}));
        end
        apb(1'b0, 12'h008, 32'h0);
        xfer(4'h3, 8'hc2);
        chk(rd[1], 1'b1);
        addr_select_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        xfer(4'h3, 8'hc2);
        chk(rd[1], 1'b0);
        ext_reset_n <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(ctrl_byte, 8'h00);
        chk(out_pin_oe_n, 2'b11);
        ext_reset_n <= 1'b1;
        repeat (4) @(posedge pclk);
        xfer(4'h1, 8'hc3);
        xfer(4'he, 8'hff);
        chk(rd[15:8], {6'h0, out_pin_i});
        results();
    end
endmodule
